//--- design/sst_segment_channel.sv
// Segmenting stream channel with pipelined sequences, Wishbone slave
// ---------------------------------------------------------------
// Functional notes
// - Large option: segments to 63, spanning windows
// - Long messages split into several segments
// - Control byte sums length, 64, 128 flags
// - Nothing pending: write zero idle control byte
// - Acknowledge sequence only after fully processed
// - Packed option: fill space, set next flag
// - Sequence stages step on bus cycles
// - Forward: up to seven unacknowledged sequences
// - Forward enabled inbound; outbound never allowed
// - Wait pacing delay before next inbound window
// - Pacing delays outbound acks, inbound delivery
// - Count ahead of ack: take data, copy count
// - Window free only within forward limit
// - Move part into window, bump count, repeat
// - Inbound delivered only once acknowledged
// - Default: segment shorter than window, control first
// - Count jump: stop, ignore until retried
// - Repeated ack closes and resyncs channel
// - Last flag ends message; next starts anew
// ---------------------------------------------------------------
//
// Added by the designer: the Wishbone slave port and the register offsets.
module sst_segment_channel import sst_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [7:0] txData,
  input wire logic [15:0] txLength,
  input wire logic txValid,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxEnd,
  input wire logic rxReady
);

  // ---------------------------------------------------------------
  // Reset release and microsecond divider
  // ---------------------------------------------------------------
  logic rstStageN, rstLocalN;
  logic [4:0] usCount;
  logic usTick, busTick;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstStageN <= 1'b0;
      rstLocalN <= 1'b0;
    end else begin
      rstStageN <= 1'b1;
      rstLocalN <= rstStageN;
    end
  end

  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      usCount <= 5'h00;
    end else if (usTick) begin
      usCount <= 5'h00;
    end else begin
      usCount <= usCount + 5'h01;
    end
  end

  assign usTick = (usCount == US_DIV_LAST);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [31:0] ctrlReg;
  logic [15:0] delayUs, busUs;
  logic [7:0] outSeq, outAck, inSeq, inAck;
  logic [7:0] outWin [WIN_BYTES];
  logic [7:0] inWin [WIN_BYTES];
  logic [7:0] inBuild [WIN_BYTES];
  logic [7:0] outShadow [WIN_BYTES];
  logic outSyncAck, inSyncAck, inBlocked, gapErr, dupErr;
  logic wbHit, wbWr, gapHit, dupHit, ackWr;
  logic [31:0] readMux;
  logic [31:0] delayMerge, busMerge;

  assign wbHit = cyc_i && stb_i && !ack_o;
  assign wbWr = wbHit && we_i;

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] val,
                                        logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b+:8] = val[8*b+:8];
      end
    end
    return res;
  endfunction

  function automatic logic [3:0] clampSize(logic [3:0] s);
    logic [3:0] r;
    r = s;
    if (s < WIN_MIN) begin
      r = WIN_MIN;
    end else if (s > WIN_MAX) begin
      r = WIN_MAX;
    end
    return r;
  endfunction

  assign delayMerge = merge({16'h0000, delayUs}, dat_i, sel_i);
  assign busMerge = merge({16'h0000, busUs}, dat_i, sel_i);

  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wbHit;
    end
  end

  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      ctrlReg <= CTRL_RESET;
      delayUs <= DELAY_RESET;
      busUs <= BUSCYC_RESET;
      outSeq <= SEQ_RESET;
      for (int i = 0; i < WIN_BYTES; i++) begin
        outWin[i] <= CB_IDLE;
      end
    end else if (wbWr) begin
      case (adr_i)
        ADDR_CTRL: ctrlReg <= merge(ctrlReg, dat_i, sel_i);
        ADDR_DELAY: delayUs <= delayMerge[15:0];
        ADDR_BUSCYC: busUs <= busMerge[15:0];
        ADDR_OUT_SEQ: if (sel_i[0]) outSeq <= dat_i[7:0];
        ADDR_OUT_WIN0, ADDR_OUT_WIN1: begin
          for (int b = 0; b < 4; b++) begin
            if (sel_i[b]) begin
              outWin[b + (adr_i[2] ? 4 : 0)] <= dat_i[8*b+:8];
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    case (adr_i)
      ADDR_CTRL: readMux = ctrlReg;
      ADDR_STATUS: readMux = {28'h0000000, dupErr, gapErr, inSyncAck, outSyncAck};
      ADDR_OUT_SEQ: readMux = {24'h000000, outSeq};
      ADDR_OUT_ACK: readMux = {24'h000000, outAck};
      ADDR_IN_SEQ: readMux = {24'h000000, inSeq};
      ADDR_IN_ACK: readMux = {24'h000000, inAck};
      ADDR_DELAY: readMux = {16'h0000, delayUs};
      ADDR_BUSCYC: readMux = {16'h0000, busUs};
      ADDR_OUT_WIN0: readMux = {outWin[3], outWin[2], outWin[1], outWin[0]};
      ADDR_OUT_WIN1: readMux = {outWin[7], outWin[6], outWin[5], outWin[4]};
      ADDR_IN_WIN0: readMux = {inWin[3], inWin[2], inWin[1], inWin[0]};
      ADDR_IN_WIN1: readMux = {inWin[7], inWin[6], inWin[5], inWin[4]};
      default: readMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      dat_o <= 32'h00000000;
    end else if (wbHit && !we_i) begin
      dat_o <= readMux;
    end
  end

  // ---------------------------------------------------------------
  // Sync handshakes and sticky errors
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      outSyncAck <= 1'b0;
    end else begin
      outSyncAck <= ctrlReg[CTRL_OUT_SYNC];
    end
  end

  // Once closed, the channel stays down until the request is withdrawn
  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      inSyncAck <= 1'b0;
      inBlocked <= 1'b0;
    end else if (!ctrlReg[CTRL_IN_SYNC]) begin
      inSyncAck <= 1'b0;
      inBlocked <= 1'b0;
    end else if (dupHit) begin
      inSyncAck <= 1'b0;
      inBlocked <= 1'b1;
    end else if (!inBlocked) begin
      inSyncAck <= 1'b1;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      gapErr <= 1'b0;
      dupErr <= 1'b0;
    end else begin
      if (gapHit) begin
        gapErr <= 1'b1;
      end else if (wbWr && adr_i == ADDR_STATUS && sel_i[0] && dat_i[ST_GAP_ERR]) begin
        gapErr <= 1'b0;
      end
      if (dupHit) begin
        dupErr <= 1'b1;
      end else if (wbWr && adr_i == ADDR_STATUS && sel_i[0] && dat_i[ST_DUP_ERR]) begin
        dupErr <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  logic inDelayStart, inDelayDone, outDelayStart, outDelayDone;

  sst_us_timer busTimer (
    .clock(clock), .rstN(rstLocalN), .start(busTick), .usTick(usTick),
    .count(busUs), .done(busTick)
  );
  sst_us_timer inDelayTimer (
    .clock(clock), .rstN(rstLocalN), .start(inDelayStart), .usTick(usTick),
    .count(delayUs), .done(inDelayDone)
  );
  sst_us_timer outDelayTimer (
    .clock(clock), .rstN(rstLocalN), .start(outDelayStart), .usTick(usTick),
    .count(delayUs), .done(outDelayDone)
  );

  // ---------------------------------------------------------------
  // Inbound acknowledge from the controller
  // ---------------------------------------------------------------
  logic [7:0] fwdLimit, inUnacked;
  logic winFree;

  assign ackWr = wbWr && adr_i == ADDR_IN_ACK && sel_i[0];
  // An ack that moves backwards or past the sent count is a repeat
  assign dupHit = ackWr && inSyncAck &&
                  ((inSeq - dat_i[7:0]) > (inSeq - inAck));
  assign inUnacked = inSeq - inAck;
  assign fwdLimit = (ctrlReg[CTRL_FWD_EN] && ctrlReg[CTRL_FWD_LIM_LSB+:3] != 3'h0) ?
                    {5'h00, ctrlReg[CTRL_FWD_LIM_LSB+:3]} : 8'h01;
  assign winFree = inUnacked < fwdLimit;

  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      inAck <= SEQ_RESET;
    end else if (!inSyncAck) begin
      inAck <= SEQ_RESET;
    end else if (ackWr && !dupHit) begin
      inAck <= dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Inbound transmitter: builds windows from the message stream
  // ---------------------------------------------------------------
  sst_in_state_t inState;
  logic [3:0] inSize, pos;
  logic [5:0] segRem;
  logic [15:0] msgRem, msgLen, segCap, segLen;
  logic [7:0] ctrlByte;
  logic optLarge, optPacked;

  assign optLarge = ctrlReg[CTRL_LARGE];
  assign optPacked = ctrlReg[CTRL_PACKED];
  assign inSize = clampSize(ctrlReg[CTRL_IN_SIZE_LSB+:4]);
  assign msgLen = (msgRem == 16'h0000) ? txLength : msgRem;
  assign segCap = optLarge ? LARGE_SEG_MAX : {12'h000, inSize - pos - 4'h1};
  assign segLen = (msgLen < segCap) ? msgLen : segCap;
  assign ctrlByte = {segLen == msgLen, optPacked, segLen[5:0]};
  assign txReady = (inState == IN_FILL) && segRem != 6'h00 && pos < inSize;

  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      inState <= IN_IDLE;
      pos <= 4'h0;
      segRem <= 6'h00;
      msgRem <= 16'h0000;
      inSeq <= SEQ_RESET;
      inDelayStart <= 1'b0;
      for (int i = 0; i < WIN_BYTES; i++) begin
        inWin[i] <= CB_IDLE;
        inBuild[i] <= CB_IDLE;
      end
    end else if (!inSyncAck) begin
      inState <= IN_IDLE;
      segRem <= 6'h00;
      msgRem <= 16'h0000;
      inSeq <= SEQ_RESET;
      inDelayStart <= 1'b0;
    end else begin
      inDelayStart <= 1'b0;
      case (inState)
        IN_IDLE: begin
          // Start gate sees the pacing timer only after it has reloaded
          if (busTick && !inDelayStart && inDelayDone && winFree &&
              (txValid || segRem != 6'h00 || msgRem != 16'h0000)) begin
            for (int i = 0; i < WIN_BYTES; i++) begin
              inBuild[i] <= CB_IDLE;
            end
            pos <= 4'h0;
            inState <= IN_FILL;
          end
        end
        IN_FILL: begin
          if (pos >= inSize) begin
            inState <= IN_COMMIT;
          end else if (segRem == 6'h00) begin
            if (msgRem == 16'h0000 && !txValid) begin
              inBuild[pos[2:0]] <= CB_IDLE;
              inState <= IN_COMMIT;
            end else if (!optLarge && pos == inSize - 4'h1) begin
              inState <= IN_COMMIT;
            end else begin
              inBuild[pos[2:0]] <= ctrlByte;
              segRem <= segLen[5:0];
              msgRem <= msgLen;
              pos <= pos + 4'h1;
            end
          end else if (txValid) begin
            inBuild[pos[2:0]] <= txData;
            pos <= pos + 4'h1;
            segRem <= segRem - 6'h01;
            msgRem <= msgRem - 16'h0001;
            if (segRem == 6'h01 && !optPacked) begin
              inState <= IN_COMMIT;
            end
          end
        end
        IN_COMMIT: begin
          for (int i = 0; i < WIN_BYTES; i++) begin
            inWin[i] <= inBuild[i];
          end
          inSeq <= inSeq + 8'h01;
          inDelayStart <= 1'b1;
          inState <= IN_IDLE;
        end
        default: inState <= IN_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outbound receiver: parses controller windows into payload bytes
  // ---------------------------------------------------------------
  sst_out_state_t outState;
  logic [3:0] outSize, rdPos;
  logic [5:0] rxSegRem;
  logic rxLastFlag, rxNextFlag;
  logic [7:0] outTaken, outDiff, curByte;

  assign outSize = clampSize(ctrlReg[CTRL_OUT_SIZE_LSB+:4]);
  assign outDiff = outSeq - outAck;
  assign curByte = outShadow[rdPos[2:0]];
  assign gapHit = outSyncAck && busTick && outState == OUT_IDLE &&
                  outDiff > 8'h01;

  always_ff @(posedge clock or negedge rstLocalN) begin
    if (!rstLocalN) begin
      outState <= OUT_IDLE;
      outAck <= SEQ_RESET;
      outTaken <= SEQ_RESET;
      rdPos <= 4'h0;
      rxSegRem <= 6'h00;
      rxLastFlag <= 1'b0;
      rxNextFlag <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      rxEnd <= 1'b0;
      outDelayStart <= 1'b0;
      for (int i = 0; i < WIN_BYTES; i++) begin
        outShadow[i] <= CB_IDLE;
      end
    end else if (!outSyncAck) begin
      outState <= OUT_IDLE;
      outAck <= SEQ_RESET;
      rxSegRem <= 6'h00;
      rxValid <= 1'b0;
      outDelayStart <= 1'b0;
    end else begin
      outDelayStart <= 1'b0;
      if (rxValid && rxReady) begin
        rxValid <= 1'b0;
      end
      case (outState)
        OUT_IDLE: begin
          // Only the next count in order is taken; a jump waits for a retry
          if (busTick && outDiff == 8'h01) begin
            for (int i = 0; i < WIN_BYTES; i++) begin
              outShadow[i] <= outWin[i];
            end
            outTaken <= outSeq;
            rdPos <= 4'h0;
            outState <= OUT_PARSE;
          end
        end
        OUT_PARSE: begin
          if (!rxValid || rxReady) begin
            if (rdPos >= outSize) begin
              outState <= OUT_HOLD;
              outDelayStart <= 1'b1;
            end else if (rxSegRem == 6'h00) begin
              if (curByte[5:0] == 6'h00) begin
                outState <= OUT_HOLD;
                outDelayStart <= 1'b1;
              end else begin
                rxSegRem <= curByte[5:0];
                rxLastFlag <= curByte[CB_LAST_BIT];
                rxNextFlag <= curByte[CB_NEXT_BIT];
                rdPos <= rdPos + 4'h1;
              end
            end else begin
              rxValid <= 1'b1;
              rxData <= curByte;
              rxEnd <= (rxSegRem == 6'h01) && rxLastFlag;
              rdPos <= rdPos + 4'h1;
              rxSegRem <= rxSegRem - 6'h01;
              if (rxSegRem == 6'h01 && !rxNextFlag) begin
                outState <= OUT_HOLD;
                outDelayStart <= 1'b1;
              end
            end
          end
        end
        OUT_HOLD: begin
          // Last byte must be drained and the pacing delay run out
          if ((!rxValid || rxReady) && !outDelayStart && outDelayDone) begin
            outAck <= outTaken;
            outState <= OUT_IDLE;
          end
        end
        default: outState <= OUT_IDLE;
      endcase
    end
  end

endmodule // sst_segment_channel

//--- design/sst_pkg.sv
// Shared constants and types for the segmented stream channel
package sst_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OUT_SEQ = 8'h08;
  localparam logic [7:0] ADDR_OUT_ACK = 8'h0C;
  localparam logic [7:0] ADDR_IN_SEQ = 8'h10;
  localparam logic [7:0] ADDR_IN_ACK = 8'h14;
  localparam logic [7:0] ADDR_DELAY = 8'h18;
  localparam logic [7:0] ADDR_BUSCYC = 8'h1C;
  localparam logic [7:0] ADDR_OUT_WIN0 = 8'h20;
  localparam logic [7:0] ADDR_OUT_WIN1 = 8'h24;
  localparam logic [7:0] ADDR_IN_WIN0 = 8'h28;
  localparam logic [7:0] ADDR_IN_WIN1 = 8'h2C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_OUT_SYNC = 0;
  localparam int CTRL_IN_SYNC = 1;
  localparam int CTRL_FWD_EN = 2;
  localparam int CTRL_LARGE = 3;
  localparam int CTRL_PACKED = 4;
  localparam int CTRL_FWD_LIM_LSB = 8;
  localparam int CTRL_IN_SIZE_LSB = 16;
  localparam int CTRL_OUT_SIZE_LSB = 20;
  localparam int ST_OUT_SYNC_ACK = 0;
  localparam int ST_IN_SYNC_ACK = 1;
  localparam int ST_GAP_ERR = 2;
  localparam int ST_DUP_ERR = 3;
  localparam int CB_LAST_BIT = 7;
  localparam int CB_NEXT_BIT = 6;

  // ---------------------------------------------------------------
  // Sizes and values after reset
  // ---------------------------------------------------------------
  localparam int WIN_BYTES = 8;
  localparam logic [3:0] WIN_MAX = 4'h8;
  localparam logic [3:0] WIN_MIN = 4'h2;
  localparam logic [15:0] LARGE_SEG_MAX = 16'h003F;
  localparam logic [7:0] CB_IDLE = 8'h00;
  localparam logic [31:0] CTRL_RESET = 32'h0088_0700;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [15:0] BUSCYC_RESET = 16'h00C8;
  localparam logic [7:0] SEQ_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ = 25_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int CYCLES_PER_US = CLOCK_HZ / HZ_PER_MHZ;
  localparam logic [4:0] US_DIV_LAST = 5'(CYCLES_PER_US - 1);

  // ---------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {IN_IDLE, IN_FILL, IN_COMMIT} sst_in_state_t;
  typedef enum logic [1:0] {OUT_IDLE, OUT_PARSE, OUT_HOLD} sst_out_state_t;

endpackage

//--- design/sst_us_timer.sv
// Microsecond countdown timer used for bus cycle and pacing delays
module sst_us_timer import sst_pkg::*; (
  input wire logic clock,
  input wire logic rstN,
  input wire logic start,
  input wire logic usTick,
  input wire logic [15:0] count,
  output logic done
);

  logic [15:0] remain;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      remain <= 16'h0000;
    end else if (start) begin
      remain <= count;
    end else if (usTick && remain != 16'h0000) begin
      remain <= remain - 16'h0001;
    end
  end

  assign done = (remain == 16'h0000);

endmodule // sst_us_timer

//--- dv/sst_ctrl_model.sv
// Controller model: classic Wishbone master for the channel registers
module sst_ctrl_model (
  input wire logic clock,
  input wire logic ackIn,
  input wire logic [31:0] datIn,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end
  // Waits as long as the slave needs; only the bench watchdog ends a hang
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do begin
      @(posedge clock);
    end while (ackIn !== 1'b1);
    q = datIn;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
endmodule // sst_ctrl_model

//--- dv/sst_channel_properties.sv
// Concurrent checks on the channel's top-level ports
module sst_channel_checker import sst_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [7:0] txData,
  input wire logic [15:0] txLength,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxEnd,
  input wire logic rxReady
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [15:0] delayCopy;
  wire logic req = cyc_i && stb_i && !ack_o;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) delayCopy <= DELAY_RESET;
    else if (req && we_i && adr_i == ADDR_DELAY) delayCopy <= dat_i[15:0];
  end
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (req |=> ack_o)
    else $error("request not answered in the next cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_read_holds: assert property ($changed(dat_o) |-> ack_o)
    else $error("read data moved outside an answer");
  a_unmapped_zero: assert property (req && !we_i && adr_i == 8'h40 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_delay_readback: assert property (req && !we_i && adr_i == ADDR_DELAY |=>
    dat_o[15:0] == delayCopy) else $error("pacing delay readback wrong");
  a_rx_hold: assert property (rxValid && !rxReady |=>
    rxValid && $stable(rxData) && $stable(rxEnd)) else $error("stalled byte changed");
  a_reset_quiet: assert property ($rose(rst_n) |-> (!ack_o && !rxValid && !txReady)[*2])
    else $error("outputs active before reset release");
  c_write: cover property (req && we_i);
  c_rx_last: cover property (rxValid && rxReady && rxEnd);
  c_tx_take: cover property (txValid && txReady);
endmodule // sst_channel_checker

bind sst_segment_channel sst_channel_checker checker_u (.clock(clock), .rst_n(rst_n),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .txData(txData), .txLength(txLength), .txValid(txValid),
  .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd), .rxReady(rxReady));

//--- dv/testbench.sv
// Self-checking bench for the segmented stream channel
module testbench import sst_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc, stb, we, ack, txReady, rxValid, rxEnd;
  logic [7:0] adr, rxData;
  logic [3:0] sel;
  logic [31:0] datW, datR;
  logic [7:0] txData = 8'h00;
  logic [15:0] txLength = 16'h0001;
  logic txValid = 1'b0;
  logic rxReady = 1'b0;
  logic sinkOn = 1'b0;
  int fail_count = 0;
  int checked = 0;
  always #20 clock = ~clock;
  // Sink stalls every other cycle, and only takes bytes while a scenario collects them
  always @(posedge clock) rxReady <= sinkOn && !rxReady;
  sst_segment_channel dut_u (.clock(clock), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .txData(txData), .txLength(txLength), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd), .rxReady(rxReady));
  sst_ctrl_model ctrl_u (.clock(clock), .ackIn(ack), .datIn(datR), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .dat(datW));
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ctrl_u.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    ctrl_u.access(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      ctrl_u.access(1'b0, a, 32'h0, q);
      n++;
    end while (q !== exp && n < 200);
    check(what, exp, q);
  endtask
  task automatic getBytes(input int from, input int upto, input logic endAtLast);
    int k;
    sinkOn <= 1'b1;
    for (int i = from; i <= upto; i++) begin
      k = 0;
      do begin
        @(negedge clock);
        k++;
      end while (!(rxValid === 1'b1 && rxReady === 1'b1) && k < 8000);
      check("rxData", 32'(i), {24'h0, rxData});
      check("rxEnd", {31'h0, endAtLast && i == upto}, {31'h0, rxEnd});
      @(posedge clock);
    end
    sinkOn <= 1'b0;
  endtask
  // Bytes 0x41 upwards, one message, valid held across bytes
  task automatic sendMsg(input int n);
    int k;
    for (int i = 1; i <= n; i++) begin
      txData <= 8'(8'h40 + i);
      txLength <= 16'(n);
      txValid <= 1'b1;
      k = 0;
      do begin
        @(negedge clock);
        k++;
      end while (txReady !== 1'b1 && k < 5000);
      @(posedge clock);
    end
    txValid <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    rd(ADDR_CTRL, CTRL_RESET, "ctrl reset");
    rd(ADDR_BUSCYC, {16'h0, BUSCYC_RESET}, "bus cycle reset");
    rd(ADDR_STATUS, 32'h0, "status reset");
    rd(8'h40, 32'h0, "unmapped");
    wr(ADDR_OUT_ACK, 32'h5);
    rd(ADDR_OUT_ACK, 32'h0, "outAck read-only");
  endtask
  task automatic test_outbound();
    wr(ADDR_BUSCYC, 32'h1);
    wr(ADDR_DELAY, 32'h1);
    wr(ADDR_CTRL, CTRL_RESET | 32'h3);
    rd(ADDR_STATUS, 32'h3, "sync acks");
    wr(ADDR_OUT_WIN0, 32'h0302_018A);
    wr(ADDR_OUT_WIN1, 32'h0706_0504);
    wr(ADDR_OUT_SEQ, 32'h1);
    rd(ADDR_OUT_ACK, 32'h0, "early outAck");
    getBytes(1, 7, 1'b0);
    poll(ADDR_OUT_ACK, 32'h1, "outAck 1");
    wr(ADDR_OUT_WIN0, 32'h000A_0908);
    wr(ADDR_OUT_WIN1, 32'h0);
    wr(ADDR_OUT_SEQ, 32'h2);
    getBytes(8, 10, 1'b1);
    poll(ADDR_OUT_ACK, 32'h2, "outAck 2");
  endtask
  task automatic test_gap();
    wr(ADDR_OUT_SEQ, 32'h4);
    poll(ADDR_STATUS, 32'h7, "gap flag");
    rd(ADDR_OUT_ACK, 32'h2, "outAck held");
    wr(ADDR_OUT_WIN0, 32'h0);
    wr(ADDR_OUT_SEQ, 32'h3);
    poll(ADDR_OUT_ACK, 32'h3, "retried outAck");
    wr(ADDR_STATUS, 32'h4);
    rd(ADDR_STATUS, 32'h3, "gap cleared");
  endtask
  task automatic test_inbound();
    sendMsg(3);
    poll(ADDR_IN_SEQ, 32'h1, "inSeq 1");
    rd(ADDR_IN_WIN0, 32'h4342_4183, "window 1 low");
    rd(ADDR_IN_WIN1, 32'h0, "window 1 high");
    wr(ADDR_IN_ACK, 32'h1);
    fork
      sendMsg(9);
      begin
        poll(ADDR_IN_SEQ, 32'h2, "inSeq 2");
        rd(ADDR_IN_WIN0, 32'h4342_4107, "window 2 low");
        rd(ADDR_IN_WIN1, 32'h4746_4544, "window 2 high");
        repeat (200) @(posedge clock);
        rd(ADDR_IN_SEQ, 32'h2, "inSeq unacked");
        wr(ADDR_IN_ACK, 32'h2);
      end
    join
    poll(ADDR_IN_SEQ, 32'h3, "inSeq 3");
    rd(ADDR_IN_WIN0, 32'h0049_4882, "window 3 low");
  endtask
  task automatic test_bad_ack();
    wr(ADDR_IN_ACK, 32'h9);
    poll(ADDR_STATUS, 32'h9, "repeated ack");
    rd(ADDR_IN_SEQ, 32'h0, "channel closed");
  endtask
  task automatic test_large();
    wr(ADDR_CTRL, CTRL_RESET | 32'h1);
    wr(ADDR_CTRL, CTRL_RESET | 32'h1F);
    fork
      sendMsg(9);
      begin
        poll(ADDR_IN_SEQ, 32'h1, "large inSeq 1");
        rd(ADDR_IN_WIN0, 32'h4342_41C9, "large window 1");
      end
    join
    poll(ADDR_IN_SEQ, 32'h2, "forward inSeq 2");
    rd(ADDR_IN_WIN0, 32'h0000_4948, "large window 2");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    test_reset();
    test_outbound();
    test_gap();
    test_inbound();
    test_bad_ack();
    test_large();
    stop_test();
  end
  // Whole run needs well under 20000 cycles
  initial begin
    #(40 * 60000);
    fail_count++;
    stop_test();
  end
endmodule // testbench
